// *** rtl/rwc_clk_monitor.sv ***
// Clock monitor timed by an independent slow oscillator tick.
`timescale 1ns/10ps
module rwc_clk_monitor #(
  parameter int LIMIT = 25
) (
  // Clock and control.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  // Activity of the monitored clock and the slow time base.
  input wire logic clk_seen,
  input wire logic rc_tick,
  // Result.
  output logic fail
);
  localparam int W = $clog2(LIMIT + 1);

  if (LIMIT < 2) begin : g_chk
    $error("rwc_clk_monitor: LIMIT must be at least 2");
  end

  logic [W-1:0] gap_q;

  // Any device clock activity restarts the gap; the slow ticks measure it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_q <= '0;
      fail <= 1'b0;
    end else if (ce) begin
      fail <= 1'b0;
      if (!enable || clk_seen) begin
        gap_q <= '0;
      end else if (rc_tick) begin
        if (gap_q == W'(LIMIT - 1)) begin
          fail <= 1'b1;
          gap_q <= '0;
        end else begin
          gap_q <= gap_q + W'(1);
        end
      end
    end
  end
endmodule : rwc_clk_monitor

// *** rtl/rwc_pkg.sv ***
// Shared constants for the reset, watchdog and clock monitor block.
package rwc_pkg;
  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_STATUS = 16'h1030;
  localparam logic [15:0] IDX_OPTIONS = 16'h1039;
  localparam logic [15:0] IDX_SERVICE = 16'h103A;
  localparam logic [15:0] IDX_TEST = 16'h103E;
  localparam logic [15:0] IDX_CONFIG = 16'h103F;
  // Field positions in system_options.
  localparam int OPT_CONVERTER_POWER_UP = 7;
  localparam int OPT_CONVERTER_CLOCK_SELECT = 6;
  localparam int OPT_IRQ_EDGE_SELECT = 5;
  localparam int OPT_DLY = 4;
  localparam int OPT_CME = 3;
  localparam int OPT_FORCED_CLOCK_MONITOR = 2;
  localparam int OPT_RATE_LO = 0;
  localparam logic [7:0] OPT_RESET = 8'h10;
  // Field positions in the test, config and status registers.
  localparam int TEST_INHIBIT = 2;
  localparam int CFG_WD_DISABLE = 2;
  localparam logic [7:0] CFG_FIXED_ONES = 8'h0A;
  localparam int STAT_WD_EN = 2;
  localparam int STAT_CM_EN = 3;
  localparam int STAT_SPECIAL = 4;
  localparam int STAT_ARMED = 5;
  // Watchdog service values.
  localparam logic [7:0] SVC_ARM = 8'h55;
  localparam logic [7:0] SVC_CLEAR = 8'hAA;
  // Timing, in E-clock cycles (one enabled MCLK cycle each).
  localparam int POR_DELAY_CYC = 4064;
  localparam int PIN_DRIVE_CYC = 4;
  localparam int PIN_SAMPLE_CYC = 2;
  localparam int RATE_WINDOW_CYC = 64;
  localparam int STOP_LONG_CYC = 4000;
  localparam int STOP_SHORT_CYC = 4;
  localparam int WD_BASE_LOG2 = 15;
  // Clock monitor frequency limits in Hz and the chosen trip point between them.
  localparam int CM_FAIL_HZ = 10000;
  localparam int CM_SAFE_HZ = 200000;
  localparam int CM_TRIP_HZ = 40000;
  // Vector bytes.
  localparam logic [7:0] VEC_HI_NORMAL = 8'hFF;
  localparam logic [7:0] VEC_HI_SPECIAL = 8'hBF;
  localparam logic [7:0] VEC_LO_PIN = 8'hFE;
  localparam logic [7:0] VEC_LO_CLKMON = 8'hFC;
  localparam logic [7:0] VEC_LO_WATCHDOG = 8'hFA;
  // Reset causes.
  typedef enum logic [1:0] {
    RWC_CAUSE_POR = 2'h0,
    RWC_CAUSE_PIN = 2'h1,
    RWC_CAUSE_WD = 2'h2,
    RWC_CAUSE_CM = 2'h3
  } rwc_cause_t;
  // Reset sequencer states, Gray along the usual path.
  typedef enum logic [2:0] {
    RWC_ST_POR = 3'h0,
    RWC_ST_DRIVE = 3'h1,
    RWC_ST_SETTLE = 3'h3,
    RWC_ST_HOLD = 3'h2,
    RWC_ST_RUN = 3'h6
  } rwc_state_t;
endpackage : rwc_pkg

// *** rtl/rwc_reset_ctrl.sv ***
// Reset sequencer, option registers and APB slave for reset control.
// What this block does
// - Hold reset 4064 cycles, then until pin high
// - Four causes; pin and power share a vector
// - Drive pin low four cycles, sample two later
// - Low sample means external, high means internal
// - Watchdog disable takes effect after next reset
// - Special modes start with watchdog resets inhibited
// - Timeout is E over 2^15/17/19/21
// - Rate resets zero; one early write normally
// - Service by 0x55 then 0xAA, in order
// - Uncleared enabled watchdog triggers system reset
// - Clock monitor resets when no clock edges
// - Flag below 10 kHz, never at 200 kHz
// - Watchdog stops when the clocks stop
// - Enabled monitor during stop causes reset
// - Interrupt pin: level low or falling edge
// - Stop recovery delay long or short per bit
// - Monitor enable read/write, cleared by reset
// - Forced monitor bit locks monitor on until reset
// - Vectors per cause, with special-mode page
// - Watchdog disable bit: 0 enables, 1 disables
`timescale 1ns/10ps
module rwc_reset_ctrl #(
  parameter int WD_BASE_LOG2 = rwc_pkg::WD_BASE_LOG2,
  parameter int RC_TICK_HZ = 1000000,
  parameter bit WD_DISABLE_DEFAULT = 1'b0
) (
  // Clock, reset and clock enable.
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Mode strap and clock status.
  input wire logic MODE_SPECIAL,
  input wire logic E_CLK_ACTIVE,
  input wire logic RC_TICK,
  input wire logic STOP_REQ,
  // Open-drain reset pin.
  input wire logic RESET_PIN_I,
  output logic RESET_PIN_O,
  output logic RESET_PIN_OE,
  // Interrupt pin sensing.
  input wire logic IRQ_PIN,
  input wire logic IRQ_ACK,
  output logic IRQ_REQ,
  // System outputs.
  output logic SYS_RESET_B,
  output logic [15:0] RESET_VECTOR,
  output logic CPU_RUN,
  output logic CONVERTER_POWER_UP,
  output logic CONVERTER_CLOCK_SEL
);
  localparam int CM_LIMIT = RC_TICK_HZ / rwc_pkg::CM_TRIP_HZ;

  // The trip gap must lie between the periods of the fail and safe frequencies.
  if (CM_LIMIT < 2 || RC_TICK_HZ / CM_LIMIT < rwc_pkg::CM_FAIL_HZ
      || RC_TICK_HZ / CM_LIMIT > rwc_pkg::CM_SAFE_HZ) begin : g_chk
    $error("rwc_reset_ctrl: RC_TICK_HZ gives no valid monitor trip point");
  end

  rwc_pkg::rwc_state_t state_q;
  rwc_pkg::rwc_cause_t cause_q;
  logic [11:0] seq_cnt_q;
  logic [11:0] stop_cnt_q;
  logic [7:0] options_q;
  logic [6:0] early_cnt_q;
  logic [15:0] idx;
  logic special_q, nv_wd_disable_q, wd_disable_q, inhibit_q;
  logic rate_written_q, stop_seen_q, irq_prev_q;
  logic in_run, sub_rst_n, wd_fail, cm_fail, wd_armed, wd_enable, cm_enable, clk_live;
  logic apb_start, apb_done, wr_done, reset_start;

  // Word index of the access; unaligned addresses still match for option, test and config writes.
  assign idx = PADDR[17:2];
  assign apb_start = PSEL && PENABLE && !PREADY;
  assign apb_done = PSEL && PENABLE && PREADY;
  assign wr_done = apb_done && PWRITE && CE;
  assign in_run = (state_q == rwc_pkg::RWC_ST_RUN);
  assign sub_rst_n = RST_B && in_run;
  assign reset_start = in_run && (!RESET_PIN_I || cm_fail || wd_fail);
  assign wd_enable = !wd_disable_q && !inhibit_q;
  assign cm_enable = options_q[rwc_pkg::OPT_CME] || options_q[rwc_pkg::OPT_FORCED_CLOCK_MONITOR];
  // In stop the device clocks are gone, so the monitor sees no activity.
  assign clk_live = E_CLK_ACTIVE && !STOP_REQ;

  // Address decode shared by reads and writes.
  function automatic logic is_mapped(input logic [17:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a[17:2] == rwc_pkg::IDX_STATUS
      || a[17:2] == rwc_pkg::IDX_OPTIONS || a[17:2] == rwc_pkg::IDX_SERVICE
      || a[17:2] == rwc_pkg::IDX_TEST || a[17:2] == rwc_pkg::IDX_CONFIG);
  endfunction : is_mapped

  // Vector for a cause, on the page that the mode selects.
  function automatic logic [15:0] vector_of(input rwc_pkg::rwc_cause_t c, input logic sp);
    logic [7:0] lo;
    lo = rwc_pkg::VEC_LO_PIN;
    unique case (c)
      rwc_pkg::RWC_CAUSE_WD: lo = rwc_pkg::VEC_LO_WATCHDOG;
      rwc_pkg::RWC_CAUSE_CM: lo = rwc_pkg::VEC_LO_CLKMON;
      rwc_pkg::RWC_CAUSE_POR, rwc_pkg::RWC_CAUSE_PIN: lo = rwc_pkg::VEC_LO_PIN;
    endcase
    vector_of = {sp ? rwc_pkg::VEC_HI_SPECIAL : rwc_pkg::VEC_HI_NORMAL, lo};
  endfunction : vector_of

  rwc_watchdog #(
    .BASE_LOG2(WD_BASE_LOG2)
  ) u_watchdog (
    .clk(MCLK),
    .rst_n(sub_rst_n),
    .ce(CE),
    .enable(wd_enable),
    .count_en(!STOP_REQ),
    .rate(options_q[rwc_pkg::OPT_RATE_LO +: 2]),
    .svc_wr(wr_done && idx == rwc_pkg::IDX_SERVICE && PADDR[1:0] == 2'h0),
    .svc_data(PWDATA[7:0]),
    .fail(wd_fail),
    .armed(wd_armed)
  );

  rwc_clk_monitor #(
    .LIMIT(CM_LIMIT)
  ) u_clk_monitor (
    .clk(MCLK),
    .rst_n(sub_rst_n),
    .ce(CE),
    .enable(cm_enable),
    .clk_seen(clk_live),
    .rc_tick(RC_TICK),
    .fail(cm_fail)
  );

  // Reset sequencer: power-up delay, pin drive, sample and wait for the pin.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      state_q <= rwc_pkg::RWC_ST_POR;
      cause_q <= rwc_pkg::RWC_CAUSE_POR;
      seq_cnt_q <= '0;
      RESET_PIN_OE <= 1'b0;
      SYS_RESET_B <= 1'b0;
    end else if (CE) begin
      unique case (state_q)
        rwc_pkg::RWC_ST_POR: begin
          if (seq_cnt_q == 12'(rwc_pkg::POR_DELAY_CYC - 1)) begin
            seq_cnt_q <= '0;
            state_q <= rwc_pkg::RWC_ST_HOLD;
          end else begin
            seq_cnt_q <= seq_cnt_q + 12'h001;
          end
        end
        rwc_pkg::RWC_ST_RUN: begin
          // An outside low on the pin outranks both internal causes.
          if (reset_start) begin
            state_q <= rwc_pkg::RWC_ST_DRIVE;
            RESET_PIN_OE <= 1'b1;
            SYS_RESET_B <= 1'b0;
            seq_cnt_q <= '0;
            if (!RESET_PIN_I) begin
              cause_q <= rwc_pkg::RWC_CAUSE_PIN;
            end else if (cm_fail) begin
              cause_q <= rwc_pkg::RWC_CAUSE_CM;
            end else begin
              cause_q <= rwc_pkg::RWC_CAUSE_WD;
            end
          end
        end
        rwc_pkg::RWC_ST_DRIVE: begin
          if (seq_cnt_q == 12'(rwc_pkg::PIN_DRIVE_CYC - 1)) begin
            RESET_PIN_OE <= 1'b0;
            seq_cnt_q <= '0;
            state_q <= rwc_pkg::RWC_ST_SETTLE;
          end else begin
            seq_cnt_q <= seq_cnt_q + 12'h001;
          end
        end
        rwc_pkg::RWC_ST_SETTLE: begin
          // A pin that rose slowly reads low here and is taken as external.
          if (seq_cnt_q == 12'(rwc_pkg::PIN_SAMPLE_CYC - 1)) begin
            if (!RESET_PIN_I) begin
              cause_q <= rwc_pkg::RWC_CAUSE_PIN;
            end
            seq_cnt_q <= '0;
            state_q <= rwc_pkg::RWC_ST_HOLD;
          end else begin
            seq_cnt_q <= seq_cnt_q + 12'h001;
          end
        end
        rwc_pkg::RWC_ST_HOLD: begin
          if (RESET_PIN_I) begin
            state_q <= rwc_pkg::RWC_ST_RUN;
            SYS_RESET_B <= 1'b1;
          end
        end
        default: state_q <= rwc_pkg::RWC_ST_POR;
      endcase
    end
  end

  // Vector follows the cause once the reset ends.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      RESET_VECTOR <= vector_of(rwc_pkg::RWC_CAUSE_POR, 1'b0);
    end else if (CE && state_q == rwc_pkg::RWC_ST_HOLD && RESET_PIN_I) begin
      RESET_VECTOR <= vector_of(cause_q, special_q);
    end
  end

  // Mode strap and the nonvolatile disable are caught while reset is held.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      special_q <= 1'b0;
      wd_disable_q <= 1'b0;
      inhibit_q <= 1'b0;
    end else if (CE) begin
      if (!in_run) begin
        special_q <= MODE_SPECIAL;
        wd_disable_q <= nv_wd_disable_q;
        inhibit_q <= MODE_SPECIAL;
      end else if (wr_done && idx == rwc_pkg::IDX_TEST && special_q) begin
        inhibit_q <= PWDATA[rwc_pkg::TEST_INHIBIT];
      end
    end
  end

  // Nonvolatile disable bit: survives system resets, only power-up restores it.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      nv_wd_disable_q <= WD_DISABLE_DEFAULT;
    end else if (CE && wr_done && idx == rwc_pkg::IDX_CONFIG) begin
      nv_wd_disable_q <= PWDATA[rwc_pkg::CFG_WD_DISABLE];
    end
  end

  // Count of cycles since reset for the one-time rate write window.
  always_ff @(posedge MCLK) begin
    if (!sub_rst_n) begin
      early_cnt_q <= '0;
    end else if (CE && early_cnt_q != 7'(rwc_pkg::RATE_WINDOW_CYC)) begin
      early_cnt_q <= early_cnt_q + 7'h01;
    end
  end

  // Option register; in normal modes the rate field takes one write, only within the early window.
  always_ff @(posedge MCLK) begin
    if (!sub_rst_n) begin
      options_q <= rwc_pkg::OPT_RESET;
      rate_written_q <= 1'b0;
    end else if (CE && wr_done && idx == rwc_pkg::IDX_OPTIONS) begin
      options_q[rwc_pkg::OPT_CONVERTER_POWER_UP] <= PWDATA[rwc_pkg::OPT_CONVERTER_POWER_UP];
      options_q[rwc_pkg::OPT_CONVERTER_CLOCK_SELECT] <= PWDATA[rwc_pkg::OPT_CONVERTER_CLOCK_SELECT];
      options_q[rwc_pkg::OPT_IRQ_EDGE_SELECT] <= PWDATA[rwc_pkg::OPT_IRQ_EDGE_SELECT];
      options_q[rwc_pkg::OPT_DLY] <= PWDATA[rwc_pkg::OPT_DLY];
      options_q[rwc_pkg::OPT_CME] <= PWDATA[rwc_pkg::OPT_CME];
      // Once forced on, the monitor stays on until the next reset.
      if (PWDATA[rwc_pkg::OPT_FORCED_CLOCK_MONITOR]) begin
        options_q[rwc_pkg::OPT_FORCED_CLOCK_MONITOR] <= 1'b1;
      end
      if (special_q || (!rate_written_q
          && early_cnt_q < 7'(rwc_pkg::RATE_WINDOW_CYC))) begin
        options_q[rwc_pkg::OPT_RATE_LO +: 2] <= PWDATA[rwc_pkg::OPT_RATE_LO +: 2];
        rate_written_q <= 1'b1;
      end
    end
  end

  // Stop recovery: hold the CPU while stopped, then wait the selected delay.
  always_ff @(posedge MCLK) begin
    if (!sub_rst_n || (CE && reset_start)) begin
      CPU_RUN <= 1'b0;
      stop_seen_q <= 1'b0;
      stop_cnt_q <= '0;
    end else if (CE) begin
      if (STOP_REQ) begin
        CPU_RUN <= 1'b0;
        stop_seen_q <= 1'b1;
        stop_cnt_q <= '0;
      end else if (!stop_seen_q) begin
        CPU_RUN <= 1'b1;
      end else if (stop_cnt_q == (options_q[rwc_pkg::OPT_DLY]
          ? 12'(rwc_pkg::STOP_LONG_CYC - 1) : 12'(rwc_pkg::STOP_SHORT_CYC - 1))) begin
        CPU_RUN <= 1'b1;
        stop_seen_q <= 1'b0;
      end else begin
        stop_cnt_q <= stop_cnt_q + 12'h001;
      end
    end
  end

  // Interrupt pin: level mode follows the pin, edge mode latches a fall.
  always_ff @(posedge MCLK) begin
    if (!sub_rst_n) begin
      IRQ_REQ <= 1'b0;
      irq_prev_q <= 1'b1;
    end else if (CE) begin
      irq_prev_q <= IRQ_PIN;
      if (!options_q[rwc_pkg::OPT_IRQ_EDGE_SELECT]) begin
        IRQ_REQ <= !IRQ_PIN;
      end else if (irq_prev_q && !IRQ_PIN) begin
        IRQ_REQ <= 1'b1;
      end else if (IRQ_ACK) begin
        IRQ_REQ <= 1'b0;
      end
    end
  end

  // Converter controls leave the block as plain register bits.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      CONVERTER_POWER_UP <= 1'b0;
      CONVERTER_CLOCK_SEL <= 1'b0;
    end else if (CE) begin
      CONVERTER_POWER_UP <= options_q[rwc_pkg::OPT_CONVERTER_POWER_UP];
      CONVERTER_CLOCK_SEL <= options_q[rwc_pkg::OPT_CONVERTER_CLOCK_SELECT];
    end
  end

  // The pin is open drain: it only ever drives a low.
  always_ff @(posedge MCLK) begin
    RESET_PIN_O <= 1'b0;
  end

  // APB: one wait state, read data captured with PREADY.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else if (CE) begin
      if (apb_start) begin
        PREADY <= 1'b1;
        PSLVERR <= !is_mapped(PADDR);
        PRDATA <= '0;
        if (!PWRITE && PADDR[1:0] == 2'h0) begin
          unique case (idx)
            rwc_pkg::IDX_OPTIONS: PRDATA[7:0] <= options_q;
            rwc_pkg::IDX_TEST: PRDATA[rwc_pkg::TEST_INHIBIT] <= inhibit_q;
            rwc_pkg::IDX_CONFIG: PRDATA[7:0] <= rwc_pkg::CFG_FIXED_ONES
              | (8'(nv_wd_disable_q) << rwc_pkg::CFG_WD_DISABLE);
            rwc_pkg::IDX_STATUS: begin
              PRDATA[1:0] <= cause_q;
              PRDATA[rwc_pkg::STAT_WD_EN] <= wd_enable;
              PRDATA[rwc_pkg::STAT_CM_EN] <= cm_enable;
              PRDATA[rwc_pkg::STAT_SPECIAL] <= special_q;
              PRDATA[rwc_pkg::STAT_ARMED] <= wd_armed;
            end
            default: PRDATA <= '0;
          endcase
        end
      end else begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
      end
    end
  end
endmodule : rwc_reset_ctrl

// *** rtl/rwc_watchdog.sv ***
// Watchdog timer with ordered two-write service sequence.
`timescale 1ns/10ps
module rwc_watchdog #(
  parameter int BASE_LOG2 = 15
) (
  // Clock and control.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic count_en,
  input wire logic [1:0] rate,
  // Service writes.
  input wire logic svc_wr,
  input wire logic [7:0] svc_data,
  // Results.
  output logic fail,
  output logic armed
);
  localparam int CNT_W = BASE_LOG2 + 6;

  if (BASE_LOG2 < 1 || BASE_LOG2 > 24) begin : g_chk
    $error("rwc_watchdog: BASE_LOG2 out of range");
  end

  logic [CNT_W-1:0] cnt_q;
  logic clear;

  // Terminal count for a rate code: two to the base, times four per step.
  function automatic logic [CNT_W-1:0] last_count(input logic [1:0] r);
    logic [CNT_W:0] one;
    one = (CNT_W+1)'(1);
    last_count = CNT_W'((one << (BASE_LOG2 + 2 * int'(r))) - one);
  endfunction : last_count

  assign clear = svc_wr && armed && (svc_data == rwc_pkg::SVC_CLEAR);

  // Arming: only the arm value arms, only the clear value after arming disarms.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (ce && svc_wr) begin
      if (svc_data == rwc_pkg::SVC_ARM) begin
        armed <= 1'b1;
      end else if (clear) begin
        armed <= 1'b0;
      end
    end
  end

  // Free-running count; it stops with the clocks, so stop mode cannot trip it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      fail <= 1'b0;
    end else if (ce) begin
      fail <= 1'b0;
      if (clear || !enable) begin
        cnt_q <= '0;
      end else if (count_en) begin
        if (cnt_q == last_count(rate)) begin
          fail <= 1'b1;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + CNT_W'(1);
        end
      end
    end
  end
endmodule : rwc_watchdog

// *** tb/rwc_pin_model.sv ***
// External reset circuit that shares the open-drain reset pin with the block.
`timescale 1ns/10ps
module rwc_pin_model (
  // Bench control of the external circuit.
  input wire logic hold_low,
  // Device side of the pin.
  input wire logic dev_oe,
  input wire logic dev_o,
  // Resolved pin level.
  output logic pin
);
  // The line has a pull-up and no slow RC, so a released pin reads high at once.
  // The bench may hold the pin low for as long as it likes, which is the slow answer.
  assign pin = ((dev_oe && !dev_o) || hold_low) ? 1'b0 : 1'b1;
endmodule : rwc_pin_model

// *** tb/rwc_reset_ctrl_chk.sv ***
// Port-level checks for the reset controller, bound to its top module.
`timescale 1ns/10ps
module rwc_reset_ctrl_chk (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_B,
  // Bus handshake.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Reset pin and system outputs.
  input wire logic RESET_PIN_I,
  input wire logic RESET_PIN_O,
  input wire logic RESET_PIN_OE,
  input wire logic SYS_RESET_B,
  input wire logic CPU_RUN,
  input wire logic [15:0] RESET_VECTOR
);
  logic [15:0] por_cnt_q;
  logic por_q;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Counts held cycles after power-up; only the first release is judged by it.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      por_cnt_q <= 16'h0000;
      por_q <= 1'b1;
    end else begin
      if (!SYS_RESET_B && por_q) por_cnt_q <= por_cnt_q + 16'h0001;
      if (SYS_RESET_B) por_q <= 1'b0;
    end
  end
  sequence s_drive;
    RESET_PIN_OE [*4];
  endsequence
  sequence s_release;
    !RESET_PIN_OE [*2];
  endsequence
  chk_pin_pulse_len: assert property ($rose(RESET_PIN_OE) |-> s_drive ##1 s_release)
    else $error("Reset pin low pulse has the wrong length.");
  chk_drive_in_reset: assert property (RESET_PIN_OE |-> !SYS_RESET_B && !RESET_PIN_O)
    else $error("Reset pin driven outside a system reset.");
  chk_pin_starts_reset: assert property (SYS_RESET_B && !RESET_PIN_I |=> RESET_PIN_OE && !SYS_RESET_B)
    else $error("Low reset pin did not start a reset.");
  chk_rise_pin_high: assert property ($rose(SYS_RESET_B) |-> $past(RESET_PIN_I))
    else $error("System left reset while the pin was low.");
  chk_por_hold_time: assert property (por_q && SYS_RESET_B |-> por_cnt_q >= 16'(rwc_pkg::POR_DELAY_CYC))
    else $error("Power-up reset released too early.");
  chk_vector_valid: assert property ($rose(SYS_RESET_B) |-> RESET_VECTOR[7:0] inside {8'hFE, 8'hFC, 8'hFA})
    else $error("Reset vector is not one of the cause vectors.");
  chk_cpu_held: assert property (!SYS_RESET_B |-> !CPU_RUN)
    else $error("CPU runs during reset.");
  chk_bus_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("Bus access not answered after one wait state.");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("Ready stayed high for more than one cycle.");
  chk_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("Error flag raised without ready.");
endmodule : rwc_reset_ctrl_chk
bind rwc_reset_ctrl rwc_reset_ctrl_chk u_chk (
  .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RESET_PIN_I(RESET_PIN_I), .RESET_PIN_O(RESET_PIN_O),
  .RESET_PIN_OE(RESET_PIN_OE), .SYS_RESET_B(SYS_RESET_B), .CPU_RUN(CPU_RUN),
  .RESET_VECTOR(RESET_VECTOR)
);

// *** tb/test_reset_watchdog_clock_monitor.sv ***
// Self-checking bench for the reset, watchdog and clock monitor block.
`timescale 1ns/10ps
module test_reset_watchdog_clock_monitor;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic e_active = 1'b1;
  logic rc_tick = 1'b0;
  logic [1:0] rc_div = 2'h0;
  logic stop_req = 1'b0;
  logic irq_pin = 1'b1;
  logic irq_ack = 1'b0;
  logic hold_low = 1'b0;
  logic mode_sp = 1'b0;
  logic conv_pu, conv_cs;
  logic pin, pin_o, pin_oe, pready, pslverr, sys_rst_b, cpu_run, irq_req, err;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] vec;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n = 0;
  // A short watchdog base keeps the longest timeout near a thousand cycles.
  rwc_reset_ctrl #(.WD_BASE_LOG2(4)) u_dut (
    .MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MODE_SPECIAL(mode_sp), .E_CLK_ACTIVE(e_active), .RC_TICK(rc_tick),
    .STOP_REQ(stop_req), .RESET_PIN_I(pin), .RESET_PIN_O(pin_o), .RESET_PIN_OE(pin_oe),
    .IRQ_PIN(irq_pin), .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req), .SYS_RESET_B(sys_rst_b),
    .RESET_VECTOR(vec), .CPU_RUN(cpu_run), .CONVERTER_POWER_UP(conv_pu),
    .CONVERTER_CLOCK_SEL(conv_cs)
  );
  rwc_pin_model u_pin (.hold_low(hold_low), .dev_oe(pin_oe), .dev_o(pin_o), .pin(pin));
  // Clock at 125 MHz.
  always #4 mclk = ~mclk;
  // Slow oscillator tick every fourth cycle, free-running and unrelated to bus traffic.
  always @(posedge mclk) begin
    rc_div <= rc_div + 2'h1;
    rc_tick <= (rc_div == 2'h3);
  end
  // Cuts a hang short well past the expected run length.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One transfer; the idle cycle after it keeps back-to-back calls from clashing.
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rdc(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd & mask, exp);
  endtask : rdc
  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr
  // Counts cycles until reset (sel 0) or run (sel 1) reaches the wanted level.
  task automatic wt(input logic sel, input logic lvl, input int max);
    n = 0;
    while (((sel ? cpu_run : sys_rst_b) !== lvl) && n < max) begin
      @(posedge mclk);
      n = n + 1;
    end
  endtask : wt
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // Main sequence; the watchdog runs from the first release, so early steps are timed.
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    wt(1'b0, 1'b1, 5000);
    chk(32'(n inside {[4064:4068]}), 32'h1);
    rdc(rwc_pkg::IDX_OPTIONS, 32'hFF, 32'h10);
    wr(rwc_pkg::IDX_OPTIONS, 8'h13);
    wr(rwc_pkg::IDX_OPTIONS, 8'h10);
    rdc(rwc_pkg::IDX_OPTIONS, 32'hFF, 32'h13);
    rdc(rwc_pkg::IDX_CONFIG, 32'hFF, 32'h0A);
    rdc(rwc_pkg::IDX_SERVICE, 32'hFF, 32'h00);
    apb(1'b0, 16'h1000, 8'h00);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    wr(rwc_pkg::IDX_SERVICE, 8'h55);
    rdc(rwc_pkg::IDX_STATUS, 32'h3F, 32'h24);
    wr(rwc_pkg::IDX_SERVICE, 8'h12);
    rdc(rwc_pkg::IDX_STATUS, 32'h3F, 32'h24);
    wr(rwc_pkg::IDX_SERVICE, 8'hAA);
    rdc(rwc_pkg::IDX_STATUS, 32'h3F, 32'h04);
    wt(1'b0, 1'b0, 1200);
    chk(32'(n inside {[1000:1030]}), 32'h1);
    wt(1'b0, 1'b1, 100);
    chk({16'h0000, vec}, 32'hFFFA);
    rdc(rwc_pkg::IDX_STATUS, 32'h3F, 32'h06);
    wr(rwc_pkg::IDX_CONFIG, 8'h04);
    wt(1'b0, 1'b0, 40);
    chk(32'(n inside {[4:14]}), 32'h1);
    wt(1'b0, 1'b1, 100);
    rdc(rwc_pkg::IDX_STATUS, 32'h3F, 32'h02);
    repeat (100) @(posedge mclk);
    chk(32'(sys_rst_b), 32'h1);
    // Clock loss with the monitor off must pass unnoticed; forcing it on must not.
    e_active <= 1'b0;
    repeat (150) @(posedge mclk);
    chk(32'(sys_rst_b), 32'h1);
    wr(rwc_pkg::IDX_OPTIONS, 8'h1C);
    wr(rwc_pkg::IDX_OPTIONS, 8'h10);
    rdc(rwc_pkg::IDX_OPTIONS, 32'hFF, 32'h14);
    wt(1'b0, 1'b0, 200);
    chk(32'(n inside {[40:130]}), 32'h1);
    e_active <= 1'b1;
    wt(1'b0, 1'b1, 100);
    chk({16'h0000, vec}, 32'hFFFC);
    rdc(rwc_pkg::IDX_STATUS, 32'h03, 32'h03);
    rdc(rwc_pkg::IDX_OPTIONS, 32'hFF, 32'h10);
    hold_low <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(32'(sys_rst_b), 32'h0);
    hold_low <= 1'b0;
    wt(1'b0, 1'b1, 20);
    chk({16'h0000, vec}, 32'hFFFE);
    rdc(rwc_pkg::IDX_STATUS, 32'h03, 32'h01);
    irq_pin <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(irq_req), 32'h1);
    irq_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(irq_req), 32'h0);
    wr(rwc_pkg::IDX_OPTIONS, 8'hF0);
    irq_pin <= 1'b0;
    @(posedge mclk);
    irq_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(irq_req), 32'h1);
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(irq_req), 32'h0);
    chk({30'h0, conv_pu, conv_cs}, 32'h3);
    // Monitor enable is already clear here, as it must be before stopping.
    stop_req <= 1'b1;
    e_active <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(32'(cpu_run), 32'h0);
    stop_req <= 1'b0;
    e_active <= 1'b1;
    wt(1'b1, 1'b1, 4100);
    chk(32'(n inside {[3995:4010]}), 32'h1);
    wr(rwc_pkg::IDX_OPTIONS, 8'h20);
    stop_req <= 1'b1;
    repeat (10) @(posedge mclk);
    stop_req <= 1'b0;
    wt(1'b1, 1'b1, 40);
    chk(32'(n inside {[2:8]}), 32'h1);
    // Special mode: watchdog starts inhibited, rate writable at any time.
    wr(rwc_pkg::IDX_CONFIG, 8'h00);
    mode_sp <= 1'b1;
    hold_low <= 1'b1;
    repeat (10) @(posedge mclk);
    hold_low <= 1'b0;
    wt(1'b0, 1'b1, 20);
    chk({16'h0000, vec}, 32'hBFFE);
    rdc(rwc_pkg::IDX_STATUS, 32'h1F, 32'h11);
    wr(rwc_pkg::IDX_OPTIONS, 8'h13);
    wr(rwc_pkg::IDX_TEST, 8'h00);
    rdc(rwc_pkg::IDX_STATUS, 32'h1F, 32'h15);
    rdc(rwc_pkg::IDX_OPTIONS, 32'h03, 32'h03);
    final_report();
  end
endmodule : test_reset_watchdog_clock_monitor
